// ===== rtl/acr_pkg.sv
package acr_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] ACR_IDX_CH6_CFG = 6'h27;
	localparam logic [5:0] ACR_IDX_CH6_OFS_HIGH = 6'h28;
	localparam logic [5:0] ACR_IDX_CH6_OFS_LOW = 6'h29;
	localparam logic [5:0] ACR_IDX_CH6_GAIN_HIGH = 6'h2A;
	localparam logic [5:0] ACR_IDX_CH6_GAIN_LOW = 6'h2B;
	localparam logic [5:0] ACR_IDX_CH7_CONFIG = 6'h2C;
	localparam logic [5:0] ACR_IDX_CH7_OFS_HIGH = 6'h2D;
	localparam logic [5:0] ACR_IDX_CH7_OFS_LOW = 6'h2E;
	localparam logic [5:0] ACR_IDX_CH7_GAIN_HIGH = 6'h2F;
	localparam logic [5:0] ACR_IDX_CH7_GAIN_LOW = 6'h30;
	// Registers per channel
	localparam logic [5:0] ACR_REGS_PER_CHAN = 6'h05;

	// Register kind within one channel's group
	localparam logic [2:0] ACR_K_CFG = 3'h0;
	localparam logic [2:0] ACR_K_OFS_HIGH = 3'h1;
	localparam logic [2:0] ACR_K_OFS_LOW = 3'h2;
	localparam logic [2:0] ACR_K_GAIN_HIGH = 3'h3;
	localparam logic [2:0] ACR_K_GAIN_LOW = 3'h4;

	// Field positions
	localparam int ACR_PHASE_MSB = 15;
	localparam int ACR_PHASE_LSB = 6;
	localparam int ACR_DCB_BIT = 2;
	localparam int ACR_SEL_MSB = 1;
	localparam int ACR_LOW_BYTE_LSB = 8;

	// Reset values
	localparam logic [15:0] ACR_CFG_RST = 16'h0000;
	localparam logic [23:0] ACR_OFS_RST = 24'h000000;
	localparam logic [15:0] ACR_GAIN_HIGH_RST = 16'h8000;
	localparam logic [7:0] ACR_GAIN_LOW_RST = 8'h00;

	// Converter input selection codes
	typedef enum logic [1:0] {
		ACR_SEL_NORMAL = 2'h0,
		ACR_SEL_SHORTED = 2'h1,
		ACR_SEL_TEST_POS = 2'h2,
		ACR_SEL_TEST_NEG = 2'h3
	} acr_sel_t;

	// One channel's calibration and configuration
	typedef struct packed {
		logic [9:0] phase;
		logic dcb_off;
		acr_sel_t in_sel;
		logic [23:0] ofs;
		logic [23:0] gain;
	} acr_chan_t;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} acr_apb_req_t;

	// APB answer to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} acr_apb_rsp_t;

	// Address decode result
	typedef struct packed {
		logic hit;
		logic chan;
		logic [2:0] kind;
	} acr_dec_t;

	// Whole state of the register bank
	typedef struct packed {
		acr_chan_t [1:0] ch;
		logic [1:0] dcb_act;
		logic [31:0] prdata;
		logic pslverr;
	} acr_state_t;

	localparam acr_chan_t ACR_CHAN_RST = '{
		phase: ACR_CFG_RST[ACR_PHASE_MSB:ACR_PHASE_LSB],
		dcb_off: ACR_CFG_RST[ACR_DCB_BIT],
		in_sel: acr_sel_t'(ACR_CFG_RST[ACR_SEL_MSB:0]),
		ofs: ACR_OFS_RST,
		gain: {ACR_GAIN_HIGH_RST, ACR_GAIN_LOW_RST}
	};

	localparam acr_state_t ACR_STATE_RST = '{
		ch: {ACR_CHAN_RST, ACR_CHAN_RST},
		dcb_act: 2'h0,
		prdata: 32'h00000000,
		pslverr: 1'b0
	};

endpackage

// ===== rtl/acr_regs.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// Behaviour
// - Offset is 24-bit signed, high/low split
// - Gain is 24-bit unsigned, high/low split
// - Gain resets to unity, 8000h and zero
// - Offset registers reset to zero
// - Config bits 15:6 hold signed phase delay
// - Config bit 2 disables DC block locally
// - Config bits 1:0 choose converter input
// - Config register resets to zero
// - Channel 6 config mirrors channel 7 fields
module acr_regs (
	input wire logic clk_sys,
	input wire logic rst,
	input acr_pkg::acr_apb_req_t apb_req,
	output acr_pkg::acr_apb_rsp_t apb_rsp,
	input wire logic [3:0] global_dc_block_setting,
	output acr_pkg::acr_chan_t [1:0] chan_cal,
	output logic [1:0] dc_block_active
);

	// Registered state and its next value
	acr_pkg::acr_state_t st;
	acr_pkg::acr_state_t next_st;
	// Decode of the current address
	acr_pkg::acr_dec_t dec;
	// Setup and access phase strobes
	logic setup_ph;
	logic access_ph;
	logic wr_take;
	// Low two lanes turned into a bit mask
	logic [15:0] wr_mask;

	// Map a byte address onto channel and register kind
	function automatic acr_pkg::acr_dec_t acr_decode(
		input logic [11:0] addr
	);
		acr_pkg::acr_dec_t d;
		logic [5:0] idx;
		d = '0;
		idx = addr[7:2];
		if (addr[11:8] == 4'h0 && addr[1:0] == 2'h0) begin
			// Channel 6 group first, then channel 7 group
			if (idx >= acr_pkg::ACR_IDX_CH6_CFG &&
				idx < acr_pkg::ACR_IDX_CH7_CONFIG) begin
				d.hit = 1'b1;
				d.chan = 1'b0;
				d.kind = 3'(idx - acr_pkg::ACR_IDX_CH6_CFG);
			end else if (idx >= acr_pkg::ACR_IDX_CH7_CONFIG &&
				idx <= acr_pkg::ACR_IDX_CH7_GAIN_LOW) begin
				d.hit = 1'b1;
				d.chan = 1'b1;
				d.kind = 3'(idx - acr_pkg::ACR_IDX_CH7_CONFIG);
			end
		end
		return d;
	endfunction

	// Software view of one register; reserved bits are zero
	function automatic logic [15:0] acr_read_word(
		input acr_pkg::acr_chan_t c,
		input logic [2:0] k
	);
		logic [15:0] w;
		w = 16'h0000;
		case (k)
			acr_pkg::ACR_K_CFG: begin
				w = {c.phase, 3'h0, c.dcb_off, c.in_sel};
			end
			acr_pkg::ACR_K_OFS_HIGH: begin
				w = c.ofs[23:8];
			end
			acr_pkg::ACR_K_OFS_LOW: begin
				w = {c.ofs[7:0], 8'h00};
			end
			acr_pkg::ACR_K_GAIN_HIGH: begin
				w = c.gain[23:8];
			end
			acr_pkg::ACR_K_GAIN_LOW: begin
				w = {c.gain[7:0], 8'h00};
			end
			default: begin
				w = 16'h0000;
			end
		endcase
		return w;
	endfunction

	// Merge a lane-masked write into one channel's fields
	function automatic acr_pkg::acr_chan_t acr_write(
		input acr_pkg::acr_chan_t c,
		input logic [2:0] k,
		input logic [15:0] d,
		input logic [15:0] m
	);
		acr_pkg::acr_chan_t r;
		logic [15:0] w;
		r = c;
		w = (acr_read_word(c, k) & ~m) | (d & m);
		case (k)
			acr_pkg::ACR_K_CFG: begin
				// Fields shared by both channels
				// Signed phase delay
				r.phase = w[acr_pkg::ACR_PHASE_MSB:acr_pkg::ACR_PHASE_LSB];
				r.dcb_off = w[acr_pkg::ACR_DCB_BIT];
				// Input select code
				r.in_sel = acr_pkg::acr_sel_t'(w[acr_pkg::ACR_SEL_MSB:0]);
			end
			acr_pkg::ACR_K_OFS_HIGH: begin
				r.ofs[23:8] = w;
			end
			acr_pkg::ACR_K_OFS_LOW: begin
				r.ofs[7:0] = w[15:acr_pkg::ACR_LOW_BYTE_LSB];
			end
			acr_pkg::ACR_K_GAIN_HIGH: begin
				r.gain[23:8] = w;
			end
			acr_pkg::ACR_K_GAIN_LOW: begin
				r.gain[7:0] = w[15:acr_pkg::ACR_LOW_BYTE_LSB];
			end
			default: begin
				r = c;
			end
		endcase
		return r;
	endfunction

	// Bus phase decode
	assign dec = acr_decode(apb_req.paddr);
	assign setup_ph = apb_req.psel && !apb_req.penable;
	assign access_ph = apb_req.psel && apb_req.penable;
	assign wr_take = access_ph && apb_req.pwrite && dec.hit;
	assign wr_mask = {{8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};

	// Next state: read capture in setup, write in access
	always_comb begin
		next_st = st;
		// Read data and error are latched in the setup cycle
		if (setup_ph) begin
			next_st.pslverr = !dec.hit;
			if (dec.hit && !apb_req.pwrite) begin
				next_st.prdata = {16'h0000,
					acr_read_word(st.ch[dec.chan], dec.kind)};
			end else begin
				// Misses and writes leave zero behind
				next_st.prdata = 32'h00000000;
			end
		end
		// Write lands at the access edge; unmapped writes dropped
		if (wr_take) begin
			next_st.ch[dec.chan] = acr_write(st.ch[dec.chan], dec.kind,
				apb_req.pwdata[15:0], wr_mask);
		end
		// DC block runs if global setting on and not disabled here
		for (int i = 0; i < 2; i++) begin
			next_st.dcb_act[i] = (global_dc_block_setting != 4'h0) &&
				!st.ch[i].dcb_off;
		end
	end

	// State register; reset gives unity gain, zero offset/config
	always_ff @(posedge clk_sys or posedge rst) begin
		// Reset loads constants only
		if (rst) begin
			st <= acr_pkg::ACR_STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	// Zero wait state answer
	assign apb_rsp.pready = access_ph;
	assign apb_rsp.prdata = st.prdata;
	assign apb_rsp.pslverr = access_ph && st.pslverr;
	// Settings towards the signal path
	assign chan_cal = st.ch;
	assign dc_block_active = st.dcb_act;

	// Checks below share the system clock and reset
	default clocking acr_cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Helper: full low-lane write to a given index
	logic full_wr;
	logic [5:0] wr_idx;
	assign full_wr = wr_take && apb_req.pstrb[1:0] == 2'h3;
	assign wr_idx = apb_req.paddr[7:2];

	// Values right after reset
	a_gain_unity_rst: assert property ($fell(rst) |->
		st.ch[0].gain == 24'h800000 && st.ch[1].gain == 24'h800000)
		else $error("gain not unity after reset");

	a_ofs_zero_rst: assert property ($fell(rst) |->
		st.ch[0].ofs == 24'h000000 && st.ch[1].ofs == 24'h000000)
		else $error("offset not zero after reset");

	a_cfg_zero_rst: assert property ($fell(rst) |->
		st.ch[1].phase == 10'h000 && !st.ch[1].dcb_off &&
		st.ch[1].in_sel == acr_pkg::ACR_SEL_NORMAL &&
		st.ch[0].phase == 10'h000 && !st.ch[0].dcb_off &&
		st.ch[0].in_sel == acr_pkg::ACR_SEL_NORMAL)
		else $error("config not zero after reset");

	// Field writes land one cycle after the access edge
	a_ofs_high_write: assert property (
		full_wr && wr_idx == acr_pkg::ACR_IDX_CH6_OFS_HIGH |=>
		st.ch[0].ofs[23:8] == $past(apb_req.pwdata[15:0]) &&
		st.ch[0].ofs[7:0] == $past(st.ch[0].ofs[7:0]))
		else $error("offset high word write wrong");

	a_ofs_ch7_high: assert property (
		full_wr && wr_idx == acr_pkg::ACR_IDX_CH7_OFS_HIGH |=>
		st.ch[1].ofs[23:8] == $past(apb_req.pwdata[15:0]) &&
		st.ch[1].ofs[7:0] == $past(st.ch[1].ofs[7:0]))
		else $error("channel 7 offset high wrong");

	a_ofs_lane_keep: assert property (
		wr_take && !apb_req.pstrb[1] &&
		wr_idx == acr_pkg::ACR_IDX_CH6_OFS_LOW |=>
		st.ch[0].ofs == $past(st.ch[0].ofs))
		else $error("offset changed by masked write");

	a_ofs_split_write: assert property (
		full_wr && wr_idx == acr_pkg::ACR_IDX_CH7_OFS_LOW |=>
		st.ch[1].ofs[7:0] == $past(apb_req.pwdata[15:8]) &&
		st.ch[1].ofs[23:8] == $past(st.ch[1].ofs[23:8]))
		else $error("offset low byte write wrong");

	a_gain_high_write: assert property (
		full_wr && wr_idx == acr_pkg::ACR_IDX_CH6_GAIN_HIGH |=>
		st.ch[0].gain[23:8] == $past(apb_req.pwdata[15:0]) &&
		st.ch[0].gain[7:0] == $past(st.ch[0].gain[7:0]))
		else $error("gain high word write wrong");

	a_gain_low_write: assert property (
		full_wr && wr_idx == acr_pkg::ACR_IDX_CH7_GAIN_LOW |=>
		st.ch[1].gain[7:0] == $past(apb_req.pwdata[15:8]) &&
		st.ch[1].gain[23:8] == $past(st.ch[1].gain[23:8]))
		else $error("gain low byte write wrong");

	a_gain_ch7_high: assert property (
		full_wr && wr_idx == acr_pkg::ACR_IDX_CH7_GAIN_HIGH |=>
		st.ch[1].gain[23:8] == $past(apb_req.pwdata[15:0]) &&
		st.ch[1].gain[7:0] == $past(st.ch[1].gain[7:0]))
		else $error("channel 7 gain high write wrong");

	a_phase_field_wr: assert property (
		full_wr && wr_idx == acr_pkg::ACR_IDX_CH7_CONFIG |=>
		st.ch[1].phase == $past(apb_req.pwdata[15:6]))
		else $error("phase delay field wrong");

	a_dcb_follow: assert property (
		full_wr && wr_idx == acr_pkg::ACR_IDX_CH7_CONFIG &&
		apb_req.pwdata[2] ##1 !access_ph |=> !dc_block_active[1])
		else $error("dc block not disabled");

	a_dcb_global_on: assert property (
		!rst && global_dc_block_setting != 4'h0 &&
		!st.ch[1].dcb_off |=> dc_block_active[1])
		else $error("dc block not following global");

	a_sel_field_wr: assert property (
		full_wr && wr_idx == acr_pkg::ACR_IDX_CH7_CONFIG |=>
		st.ch[1].in_sel == $past(apb_req.pwdata[1:0]))
		else $error("input select wrong");

	// Reserved bits always read back as zero
	a_resv_read_zero: assert property (
		setup_ph && !apb_req.pwrite && dec.hit &&
		dec.kind == acr_pkg::ACR_K_CFG |=>
		apb_rsp.prdata[5:3] == 3'h0 && apb_rsp.prdata[31:16] == 16'h0000)
		else $error("reserved config bits read non-zero");

	a_resv_low_zero: assert property (
		setup_ph && !apb_req.pwrite && dec.hit &&
		(dec.kind == acr_pkg::ACR_K_OFS_LOW ||
		dec.kind == acr_pkg::ACR_K_GAIN_LOW) |=>
		apb_rsp.prdata[7:0] == 8'h00 && apb_rsp.prdata[31:16] == 16'h0000)
		else $error("reserved low bits read non-zero");

	a_ch6_cfg_fields: assert property (
		full_wr && wr_idx == acr_pkg::ACR_IDX_CH6_CFG |=>
		st.ch[0].in_sel == $past(apb_req.pwdata[1:0]) &&
		st.ch[0].dcb_off == $past(apb_req.pwdata[2]) &&
		st.ch[1] == $past(st.ch[1]))
		else $error("channel 6 config wrong");

	a_ch6_phase_wr: assert property (
		full_wr && wr_idx == acr_pkg::ACR_IDX_CH6_CFG |=>
		st.ch[0].phase == $past(apb_req.pwdata[15:6]))
		else $error("channel 6 phase delay wrong");

	// Main scenarios reached by the bench
	c_write_gain: cover property (full_wr &&
		wr_idx == acr_pkg::ACR_IDX_CH7_GAIN_LOW);
	c_read_offset: cover property (setup_ph && !apb_req.pwrite &&
		dec.kind == acr_pkg::ACR_K_OFS_LOW ##1 access_ph);
	c_unmapped: cover property (access_ph && apb_rsp.pslverr);
	c_test_input: cover property (st.ch[1].in_sel ==
		acr_pkg::ACR_SEL_TEST_NEG);
	c_dcb_local_off: cover property (global_dc_block_setting != 4'h0 &&
		!dc_block_active[1]);

endmodule

// ===== bench/tb_acr_regs.sv
`timescale 1ns/1ps
module tb_acr_regs;
	logic clk_sys = 1'b0; // System clock
	logic rst = 1'b1; // Reset, active high
	acr_pkg::acr_apb_req_t req = '0; // Bus request
	acr_pkg::acr_apb_rsp_t rsp; // Bus answer
	logic [3:0] glb = 4'h0; // Global DC block setting
	acr_pkg::acr_chan_t [1:0] cal; // Channel settings
	logic [1:0] dca; // DC block state
	logic [15:0] mdl [10]; // Expected register contents
	logic [11:0] bad [4] = '{12'h098, 12'h0C4, 12'h0A1, 12'h1B4};
	int mismatches = 0;
	int checks = 0;
	logic [31:0] rd; // Read data seen
	logic err; // Error flag seen

	acr_regs dut_u (.clk_sys(clk_sys), .rst(rst), .apb_req(req),
		.apb_rsp(rsp), .global_dc_block_setting(glb),
		.chan_cal(cal), .dc_block_active(dca));

	// Clock, 5 ns period
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Counts, verdict, end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Compare seen with expected
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value at %0t: %h not %h", $time, s, e);
		end
	endtask

	// Writable bits by register index
	function automatic logic [15:0] wmask(input int i);
		case (i % 5)
			0: return 16'hFFC7;
			2, 4: return 16'hFF00;
			default: return 16'hFFFF;
		endcase
	endfunction

	// One APB transfer, idle cycle first
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [15:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_sys);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
			pwdata: {16'h0000, d}, pstrb: s};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (rsp.pready !== 1'b1 && n < 16);
		if (rsp.pready !== 1'b1) begin
			mismatches++;
			summarize();
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	// Byte address of a register index
	function automatic logic [11:0] adr(input int i);
		return {4'h0, acr_pkg::ACR_IDX_CH6_CFG + 6'(i), 2'h0};
	endfunction

	// Write and track lanes and reserved bits
	task automatic wr(input int i, input logic [15:0] d,
		input logic [3:0] s);
		logic [15:0] m;
		m = {{8{s[1]}}, {8{s[0]}}};
		apb(1'b1, adr(i), d, s);
		mdl[i] = ((mdl[i] & ~m) | (d & m)) & wmask(i);
		chk(32'(err), 32'h0);
	endtask

	// Read back one register
	task automatic rdchk(input int i);
		apb(1'b0, adr(i), 16'h0000, 4'h0);
		chk(rd, {16'h0000, mdl[i]});
		chk(32'(err), 32'h0);
	endtask

	// Channel outputs against the register model
	task automatic chan_chk();
		int b;
		@(posedge clk_sys);
		#1;
		for (int c = 0; c < 2; c++) begin
			b = 5 * c;
			chk(32'(cal[c].ofs), {8'h00, mdl[b+1], mdl[b+2][15:8]});
			chk(32'(cal[c].gain), {8'h00, mdl[b+3], mdl[b+4][15:8]});
			chk(32'(cal[c].phase), 32'(mdl[b][15:6]));
			chk(32'(cal[c].dcb_off), 32'(mdl[b][2]));
			chk(32'(cal[c].in_sel), 32'(mdl[b][1:0]));
			chk(32'(dca[c]), 32'((glb != 4'h0) && !mdl[b][2]));
		end
	endtask

	// Reset pulse and model reset
	task automatic reset();
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			mdl[i] = (i % 5 == 3) ? 16'h8000 : 16'h0000;
		end
	endtask

	// Read every register, then outputs
	task automatic sweep();
		for (int i = 0; i < 10; i++) begin
			rdchk(i);
		end
		chan_chk();
	endtask

	// Main sequence
	initial begin
		logic [15:0] d;
		int i;
		void'($urandom(32'h35A3B633));
		reset();
		sweep();
		// Random writes; first ones step every input code
		for (int k = 0; k < 40; k++) begin
			i = (k < 8) ? 5 * (k % 2) : $urandom_range(9);
			d = 16'($urandom);
			if (i % 5 == 0 && k < 8) begin
				d[1:0] = 2'(k >> 1);
			end
			glb <= (k % 3 == 0) ? 4'h0 : 4'($urandom);
			wr(i, d, (k < 10) ? 4'hF : 4'($urandom));
			chan_chk();
			rdchk(i);
		end
		// Unmapped places refuse and read zero
		foreach (bad[j]) begin
			apb(1'b1, bad[j], 16'($urandom), 4'hF);
			chk(32'(err), 32'h1);
			apb(1'b0, bad[j], 16'h0000, 4'h0);
			chk(32'(err), 32'h1);
			chk(rd, 32'h0);
		end
		sweep();
		// Second reset in mid-run
		reset();
		sweep();
		summarize();
	end
endmodule
